// [common/sfpi_consts.svh]
// constants for the serial flash pin front end
`ifndef SFPI_CONSTS_SVH
`define SFPI_CONSTS_SVH
`define SFPI_BYTE_W 8
`define SFPI_LANES 4
`define SFPI_CNT_W 3
`define SFPI_STEP_1 3'h1
`define SFPI_STEP_2 3'h2
`define SFPI_STEP_4 3'h4
`define SFPI_UNDERRUN_BYTE 8'hFF
`define SFPI_LANES_OFF 4'h0
`define SFPI_OE_SINGLE 4'h2
`define SFPI_OE_DUAL 4'h3
`define SFPI_OE_QUAD 4'hF
`endif

// [common/sfpi_pkg.sv]
// types of the serial flash pin front end
`include "sfpi_consts.svh"
package sfpi_pkg;
  typedef enum logic [2:0] {
    SFPI_CMD,
    SFPI_OUT1,
    SFPI_OUT2,
    SFPI_OUT4,
    SFPI_IN4
  } sfpi_mode_t;

  typedef struct packed {
    logic rst_q;
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic rxt_s1_q;
    logic rxt_s2_q;
    logic rxt_s3_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic wp_s1_q;
    logic wp_s2_q;
    sfpi_mode_t mode_q;
    logic tx_tog_q;
    logic [`SFPI_BYTE_W-1:0] tx_hold_q;
    logic tx_ready_q;
    logic rx_valid_q;
    logic [`SFPI_BYTE_W-1:0] rx_data_q;
    logic frame_start_q;
    logic frame_end_q;
    logic standby_q;
    logic protect_lock_q;
  } sfpi_sys_t;

  typedef struct packed {
    sfpi_mode_t mode_s1_q;
    sfpi_mode_t mode_s2_q;
    logic [`SFPI_BYTE_W-1:0] sh_q;
    logic [`SFPI_CNT_W-1:0] cnt_q;
  } sfpi_rise_t;

  typedef struct packed {
    logic [`SFPI_BYTE_W-1:0] byte_q;
    logic tog_q;
  } sfpi_rise_keep_t;

  typedef struct packed {
    sfpi_mode_t mode_s1_q;
    sfpi_mode_t mode_s2_q;
    logic [`SFPI_LANES-1:0] oe_q;
    logic [`SFPI_LANES-1:0] out_q;
    logic [`SFPI_BYTE_W-1:0] sh_q;
    logic [`SFPI_CNT_W-1:0] cnt_q;
  } sfpi_fall_t;

  typedef struct packed {
    logic tx_s1_q;
    logic tx_s2_q;
    logic ack_q;
  } sfpi_fall_keep_t;
endpackage : sfpi_pkg

// [hdl/sfpi_core.sv]
// serial flash pin front end: framing, lane direction, bit capture and launch
// Functional notes
// - a falling chip select starts a new operation
// - a rising chip select ends the current operation
// - deselected device reports standby
// - standby waits while internal program or erase is busy
// - command, address and write bits captured on rising serial clock
// - read bits launched on falling serial clock
// - dual and quad reads turn lane zero into an output
// - lane zero input ignored while deselected
// - serial output high impedance while deselected
// - dual reads drive lanes one and zero, two bits per falling edge
// - low write-protect input gates hardware locking of protection
// - quad program samples four bits per rising edge, lane two included
// - quad reads drive lane two, four bits per falling edge
// - write-protect defaults high when left floating
// - hold pauses transfer: clock and input ignored, output floats
// - quad program and quad read use hold pin as lane three
module sfpi_core
  import sfpi_pkg::*;
(
  // system clock and reset
  input wire logic clock,
  input wire logic rst,
  // serial link from the host
  input wire logic sck,
  input wire logic cs_n,
  input wire logic data_lane0_in,
  output logic data_lane0_out,
  output logic data_lane0_oe,
  input wire logic data_lane1_in,
  output logic data_lane1_out,
  output logic data_lane1_oe,
  input wire logic data_lane2_in,
  output logic data_lane2_out,
  output logic data_lane2_oe,
  input wire logic data_lane3_in,
  output logic data_lane3_out,
  output logic data_lane3_oe,
  // lane mode request from the command decoder
  input wire sfpi_pkg::sfpi_mode_t lane_mode,
  // received bytes
  output logic [7:0] rx_data,
  output logic rx_valid,
  // read bytes to send
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // framing and power
  output logic frame_start,
  output logic frame_end,
  input wire logic busy,
  output logic standby,
  output logic protect_lock
);
  import sfpi_pkg::*;

  function automatic logic [2:0] lane_step(input sfpi_mode_t m);
    logic [2:0] s;
    s = `SFPI_STEP_1;
    if (m == SFPI_OUT2)
    begin
      s = `SFPI_STEP_2;
    end
    else if (m == SFPI_OUT4 || m == SFPI_IN4)
    begin
      s = `SFPI_STEP_4;
    end
    return s;
  endfunction : lane_step

  function automatic logic [3:0] lane_oe(input sfpi_mode_t m);
    logic [3:0] oe;
    oe = `SFPI_LANES_OFF;
    unique case (m)
      SFPI_OUT1: oe = `SFPI_OE_SINGLE;
      SFPI_OUT2: oe = `SFPI_OE_DUAL;
      SFPI_OUT4: oe = `SFPI_OE_QUAD;
      SFPI_CMD, SFPI_IN4: oe = `SFPI_LANES_OFF;
      default: oe = `SFPI_LANES_OFF;
    endcase
    return oe;
  endfunction : lane_oe

  // a quad mode gives the protect and hold pins over to data
  function automatic logic is_quad(input sfpi_mode_t m);
    return m == SFPI_OUT4 || m == SFPI_IN4;
  endfunction : is_quad

  sfpi_sys_t s_q;
  sfpi_sys_t s_d;
  sfpi_rise_t r_q;
  sfpi_rise_t r_d;
  sfpi_rise_keep_t rk_q;
  sfpi_rise_keep_t rk_d;
  sfpi_fall_t f_q;
  sfpi_fall_t f_d;
  sfpi_fall_keep_t fk_q;
  sfpi_fall_keep_t fk_d;

  logic hold_active_r;
  logic hold_active_f;
  logic [3:0] rx_sum;
  logic [7:0] tx_src;
  logic tx_pending;
  logic [2:0] fstep;

  // system domain
  always_comb
  begin
    s_d = s_q;
    s_d.rst_q = rst;
    s_d.cs_s1_q = cs_n;
    s_d.cs_s2_q = s_q.cs_s1_q;
    s_d.cs_s3_q = s_q.cs_s2_q;
    s_d.rxt_s1_q = rk_q.tog_q;
    s_d.rxt_s2_q = s_q.rxt_s1_q;
    s_d.rxt_s3_q = s_q.rxt_s2_q;
    s_d.ack_s1_q = fk_q.ack_q;
    s_d.ack_s2_q = s_q.ack_s1_q;
    s_d.wp_s1_q = data_lane2_in;
    s_d.wp_s2_q = s_q.wp_s1_q;
    s_d.frame_start_q = s_q.cs_s3_q && !s_q.cs_s2_q;
    s_d.frame_end_q = !s_q.cs_s3_q && s_q.cs_s2_q;
    // lane mode falls back to command input once deselected
    s_d.mode_q = s_q.cs_s2_q ? SFPI_CMD : lane_mode;
    s_d.rx_valid_q = s_q.rxt_s2_q != s_q.rxt_s3_q;
    // link byte is stable for at least two serial clocks after its toggle
    if (s_q.rxt_s2_q != s_q.rxt_s3_q)
    begin
      s_d.rx_data_q = rk_q.byte_q;
    end
    if (tx_valid && s_q.tx_ready_q)
    begin
      s_d.tx_hold_q = tx_data;
      s_d.tx_tog_q = !s_q.tx_tog_q;
      s_d.tx_ready_q = 1'b0;
    end
    else
    begin
      s_d.tx_ready_q = s_q.tx_tog_q == s_q.ack_s2_q;
    end
    s_d.standby_q = s_q.cs_s2_q && !busy;
    // floating pin reads high through the pad pull-up, so no lock
    s_d.protect_lock_q = !s_q.wp_s2_q && !is_quad(s_q.mode_q);
    if (rst)
    begin
      s_d = '0;
      s_d.rst_q = 1'b1;
      s_d.cs_s1_q = 1'b1;
      s_d.cs_s2_q = 1'b1;
      s_d.cs_s3_q = 1'b1;
      s_d.wp_s1_q = 1'b1;
      s_d.wp_s2_q = 1'b1;
      s_d.mode_q = SFPI_CMD;
      s_d.standby_q = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    s_q <= s_d;
  end

  // rising serial clock: capture
  always_comb
  begin
    r_d = r_q;
    rk_d = rk_q;
    r_d.mode_s1_q = s_q.mode_q;
    r_d.mode_s2_q = r_q.mode_s1_q;
    // hold only pauses the single lane; quad modes use the pin as data
    hold_active_r = !data_lane3_in && !is_quad(r_q.mode_s2_q);
    rx_sum = {1'b0, r_q.cnt_q} + {1'b0, lane_step(r_q.mode_s2_q)};
    if (r_q.mode_s2_q == SFPI_IN4)
    begin
      r_d.sh_q = {r_q.sh_q[3:0], data_lane3_in, data_lane2_in, data_lane1_in, data_lane0_in};
      r_d.cnt_q = rx_sum[2:0];
    end
    else if (r_q.mode_s2_q == SFPI_CMD && !hold_active_r)
    begin
      r_d.sh_q = {r_q.sh_q[6:0], data_lane0_in};
      r_d.cnt_q = rx_sum[2:0];
    end
    else
    begin
      rx_sum = 4'h0;
    end
    if (rx_sum[3])
    begin
      rk_d.byte_q = r_d.sh_q;
      rk_d.tog_q = !rk_q.tog_q;
    end
  end

  // deselect clears the partial byte and ignores lane zero; also covers idle-high clock
  // reset too: at power-up select may sit high without ever rising
  always_ff @(posedge sck or posedge cs_n or posedge s_q.rst_q)
  begin
    if (cs_n || s_q.rst_q)
    begin
      r_q <= {SFPI_CMD, SFPI_CMD, 8'h00, 3'h0};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // handshake state survives frames so a last byte is not lost
  always_ff @(posedge sck or posedge s_q.rst_q)
  begin
    if (s_q.rst_q)
    begin
      rk_q <= '0;
    end
    else
    begin
      rk_q <= rk_d;
    end
  end

  // falling serial clock: launch
  always_comb
  begin
    f_d = f_q;
    fk_d = fk_q;
    f_d.mode_s1_q = s_q.mode_q;
    f_d.mode_s2_q = f_q.mode_s1_q;
    fk_d.tx_s1_q = s_q.tx_tog_q;
    fk_d.tx_s2_q = fk_q.tx_s1_q;
    fstep = lane_step(f_q.mode_s2_q);
    hold_active_f = !data_lane3_in && !is_quad(f_q.mode_s2_q);
    tx_pending = fk_q.tx_s2_q != fk_q.ack_q;
    tx_src = f_q.sh_q;
    f_d.oe_q = lane_oe(f_q.mode_s2_q);
    if (hold_active_f)
    begin
      f_d.oe_q = `SFPI_LANES_OFF;
    end
    else if (lane_oe(f_q.mode_s2_q) != `SFPI_LANES_OFF)
    begin
      if (f_q.cnt_q == 3'h0)
      begin
        // an empty buffer sends ones rather than stalling the host
        tx_src = tx_pending ? s_q.tx_hold_q : `SFPI_UNDERRUN_BYTE;
        fk_d.ack_q = fk_q.ack_q ^ tx_pending;
      end
      unique case (f_q.mode_s2_q)
        SFPI_OUT2: f_d.out_q = {2'h0, tx_src[7:6]};
        SFPI_OUT4: f_d.out_q = tx_src[7:4];
        default: f_d.out_q = {2'h0, tx_src[7], 1'b0};
      endcase
      f_d.sh_q = tx_src << fstep;
      f_d.cnt_q = f_q.cnt_q + fstep;
    end
    else
    begin
      f_d.cnt_q = 3'h0;
    end
  end

  always_ff @(negedge sck or posedge cs_n or posedge s_q.rst_q)
  begin
    if (cs_n || s_q.rst_q)
    begin
      f_q <= {SFPI_CMD, SFPI_CMD, `SFPI_LANES_OFF, `SFPI_LANES_OFF, 8'h00, 3'h0};
    end
    else
    begin
      f_q <= f_d;
    end
  end

  always_ff @(negedge sck or posedge s_q.rst_q)
  begin
    if (s_q.rst_q)
    begin
      fk_q <= '0;
    end
    else
    begin
      fk_q <= fk_d;
    end
  end

  assign data_lane0_out = f_q.out_q[0];
  assign data_lane1_out = f_q.out_q[1];
  assign data_lane2_out = f_q.out_q[2];
  assign data_lane3_out = f_q.out_q[3];
  assign data_lane0_oe = f_q.oe_q[0];
  assign data_lane1_oe = f_q.oe_q[1];
  assign data_lane2_oe = f_q.oe_q[2];
  assign data_lane3_oe = f_q.oe_q[3];
  assign rx_data = s_q.rx_data_q;
  assign rx_valid = s_q.rx_valid_q;
  assign tx_ready = s_q.tx_ready_q;
  assign frame_start = s_q.frame_start_q;
  assign frame_end = s_q.frame_end_q;
  assign standby = s_q.standby_q;
  assign protect_lock = s_q.protect_lock_q;
endmodule : sfpi_core

// [tb/sfpi_core_assertions.sv]
// concurrent checks on the serial flash pin front end
module sfpi_core_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link pins
  input wire logic cs_n,
  input wire logic data_lane0_oe,
  input wire logic data_lane1_oe,
  input wire logic data_lane2_oe,
  input wire logic data_lane3_oe,
  input wire logic data_lane2_in,
  // framing and power
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic busy,
  input wire logic standby,
  input wire logic protect_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_sel;
    (!cs_n)[*6];
  endsequence
  sequence s_idle;
    (cs_n && !busy)[*6];
  endsequence
  a_start_pulse: assert property ($fell(cs_n) |-> ##[2:5] frame_start)
    else $error("frame start missing");
  a_end_pulse: assert property ($rose(cs_n) |-> ##[2:5] frame_end)
    else $error("frame end missing");
  a_oe_desel: assert property (cs_n [*2] |-> !(data_lane0_oe || data_lane1_oe ||
    data_lane2_oe || data_lane3_oe))
    else $error("lane driven while deselected");
  a_standby_sel: assert property (s_sel |-> !standby)
    else $error("standby while selected");
  a_standby_idle: assert property (s_idle |-> standby)
    else $error("standby not entered");
  a_standby_busy: assert property (busy [*2] |=> !standby)
    else $error("standby while busy");
  a_lock_pin: assert property ((!data_lane2_in && cs_n)[*8] |-> protect_lock)
    else $error("lock not reported");
  a_quad_lanes: assert property (data_lane2_oe |-> data_lane3_oe && data_lane1_oe && data_lane0_oe)
    else $error("quad lanes not driven together");
  a_dual_lanes: assert property (data_lane0_oe |-> data_lane1_oe)
    else $error("lane one not driven");
endmodule : sfpi_core_checker

bind sfpi_core sfpi_core_checker u_chk (
  .clock(clock), .rst(rst), .cs_n(cs_n), .data_lane0_oe(data_lane0_oe), .data_lane1_oe(data_lane1_oe),
  .data_lane2_oe(data_lane2_oe), .data_lane3_oe(data_lane3_oe), .data_lane2_in(data_lane2_in),
  .frame_start(frame_start), .frame_end(frame_end), .busy(busy), .standby(standby), .protect_lock(protect_lock)
);

// [tb/sfpi_host.sv]
// host model driving select, serial clock and data lanes
module sfpi_host (
  // pins toward the device
  output logic sck,
  output logic cs_n,
  output logic [3:0] hoe,
  output logic [3:0] hd,
  // resolved lane levels
  input wire logic [3:0] lanes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] smp;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    hoe = 4'h0;
    hd = 4'h0;
  end
  task automatic frame_on(input logic idle);
    sck = idle;
    #32;
    cs_n = 1'b0;
    #32;
  endtask : frame_on
  task automatic frame_off(input logic idle);
    sck = idle;
    #32;
    cs_n = 1'b1;
    hoe = 4'h0;
    #64;
  endtask : frame_off
  // data moves mid low phase, clear of both edges
  task automatic cyc(input logic [3:0] oe, input logic [3:0] d);
    sck = 1'b0;
    #16;
    hoe = oe;
    hd = d;
    #16;
    sck = 1'b1;
    smp = lanes;
    #32;
  endtask : cyc
  // dummies hold low on writes so no bit is taken before the mode lands
  task automatic xfer(input logic [7:0] v, input int w, input logic rd, input int dum, output logic [7:0] r);
    logic [7:0] sh;
    sh = v;
    r = 8'h00;
    repeat (dum) cyc(4'h9, rd ? 4'h8 : 4'h0);
    for (int i = 0; i < 8 / w; i++)
    begin
      if (rd)
        cyc((w == 1) ? 4'h9 : ((w == 2) ? 4'h8 : 4'h0), 4'h8);
      else
        cyc((w == 4) ? 4'hF : 4'h9, (w == 4) ? sh[7:4] : {3'h4, sh[7]});
      sh = sh << w;
      r = (w == 1) ? {r[6:0], smp[1]} : ((w == 2) ? {r[5:0], smp[1:0]} : {r[3:0], smp});
    end
  endtask : xfer
endmodule : sfpi_host

// [tb/serial_flash_pin_interface_test.sv]
// testbench for the serial flash pin front end
module serial_flash_pin_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sfpi_pkg::*;
  logic clock, rst, busy, tx_valid;
  logic [7:0] tx_data;
  sfpi_mode_t lane_mode;
  logic sck, cs_n, rx_valid, tx_ready, standby, protect_lock, frame_start, frame_end;
  int n_start = 0;
  int n_end = 0;
  logic [3:0] hoe, hd, oe, dout, lanes;
  logic [7:0] rx_data, rx_last;
  int error_cnt = 0;
  int n_checks = 0;
  // released lines: pull-up on lanes two and three, a toggling level elsewhere
  assign lanes = (oe & dout) | (~oe & hoe & hd) | (~oe & ~hoe & {2'b11, clock, clock});
  always #10 clock = ~clock;
  always @(posedge clock)
  begin
    if (rx_valid)
      rx_last <= rx_data;
    if (frame_start)
      n_start <= n_start + 1;
    if (frame_end)
      n_end <= n_end + 1;
  end
  sfpi_host host (.sck(sck), .cs_n(cs_n), .hoe(hoe), .hd(hd), .lanes(lanes));
  sfpi_core dut (
    .clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n),
    .data_lane0_in(lanes[0]), .data_lane0_out(dout[0]), .data_lane0_oe(oe[0]),
    .data_lane1_in(lanes[1]), .data_lane1_out(dout[1]), .data_lane1_oe(oe[1]),
    .data_lane2_in(lanes[2]), .data_lane2_out(dout[2]), .data_lane2_oe(oe[2]),
    .data_lane3_in(lanes[3]), .data_lane3_out(dout[3]), .data_lane3_oe(oe[3]),
    .lane_mode(lane_mode), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .frame_start(frame_start), .frame_end(frame_end),
    .busy(busy), .standby(standby), .protect_lock(protect_lock)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  task automatic t_write;
    logic [7:0] r;
    host.frame_on(1'b0);
    host.xfer(8'hA5, 1, 1'b0, 2, r);
    host.frame_off(1'b0);
    repeat (8) @(negedge clock);
    chk(rx_last, 8'hA5);
    host.frame_on(1'b1);
    repeat (3) host.cyc(4'h9, 4'h9);
    host.frame_off(1'b1);
    repeat (8) @(negedge clock);
    host.frame_on(1'b1);
    host.xfer(8'h3C, 1, 1'b0, 0, r);
    host.frame_off(1'b1);
    repeat (8) @(negedge clock);
    chk(rx_last, 8'h3C);
    $display("write test done");
  endtask : t_write
  task automatic t_read;
    sfpi_mode_t m[3];
    logic [7:0] b[3];
    logic [7:0] e[3];
    logic [7:0] r;
    m = '{SFPI_OUT1, SFPI_OUT2, SFPI_OUT4};
    b = '{8'hC6, 8'h39, 8'hB4};
    e = '{8'h02, 8'h03, 8'h0F};
    for (int i = 0; i < 3; i++)
    begin
      tx_data = b[i];
      tx_valid = 1'b1;
      @(posedge clock iff tx_ready === 1'b1);
      @(negedge clock);
      tx_valid = 1'b0;
      host.frame_on(1'b0);
      host.xfer(8'h3B, 1, 1'b0, 0, r);
      @(negedge clock);
      lane_mode = m[i];
      repeat (3) @(negedge clock);
      host.xfer(8'h00, 1 << i, 1'b1, 2, r);
      chk(r, b[i]);
      chk({4'h0, oe}, e[i]);
      @(negedge clock);
      lane_mode = SFPI_CMD;
      host.frame_off(1'b0);
      chk({4'h0, oe}, 8'h00);
      repeat (6) @(negedge clock);
    end
    $display("read test done");
  endtask : t_read
  task automatic t_quad_in;
    logic [7:0] r;
    host.frame_on(1'b0);
    host.xfer(8'h32, 1, 1'b0, 0, r);
    @(negedge clock);
    lane_mode = SFPI_IN4;
    repeat (3) @(negedge clock);
    host.xfer(8'h9E, 4, 1'b0, 2, r);
    repeat (8) @(negedge clock);
    chk(rx_last, 8'h9E);
    lane_mode = SFPI_CMD;
    host.frame_off(1'b0);
    repeat (6) @(negedge clock);
    $display("quad input test done");
  endtask : t_quad_in
  task automatic t_pins;
    int s0;
    int e0;
    s0 = n_start;
    e0 = n_end;
    busy = 1'b1;
    host.frame_on(1'b0);
    host.frame_off(1'b0);
    repeat (12) @(negedge clock);
    chk(8'(n_start - s0), 8'h01);
    chk(8'(n_end - e0), 8'h01);
    chk({7'h00, standby}, 8'h00);
    chk({4'h0, oe}, 8'h00);
    busy = 1'b0;
    repeat (8) @(negedge clock);
    chk({7'h00, standby}, 8'h01);
    host.hoe = 4'h4;
    host.hd = 4'h0;
    repeat (10) @(negedge clock);
    chk({7'h00, protect_lock}, 8'h01);
    host.hoe = 4'h0;
    repeat (10) @(negedge clock);
    chk({7'h00, protect_lock}, 8'h00);
    $display("power and protect test done");
  endtask : t_pins
  initial
  begin
    #200us;
    error_cnt++;
    $display("ERROR %0t run did not finish", $time);
    results();
  end
  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    busy = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    lane_mode = SFPI_CMD;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    t_write();
    t_read();
    t_quad_in();
    t_pins();
    results();
  end
endmodule : serial_flash_pin_interface_test
